/* File: hw/frg_gate_ctrl.sv */
// W-phase gate gating and fault response logic
`timescale 1ns/1ps
`include "frg_defs.svh"
module frg_gate_ctrl
(
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  input  wire logic                     clk_en,
  input  wire logic [`FRG_ADDR_W-1:0]   reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [31:0]              reg_rdata,
  input  wire logic                     phase_w_high_input,
  input  wire logic                     phase_w_low_input,
  input  wire frg_pkg::frg_faults_t     fault_in,
  output logic                          phase_w_high_output,
  output logic                          phase_w_low_output,
  output logic                          aux_drivers_on,
  output logic                          pump_on,
  output logic                          osc_on,
  output logic                          vds_monitor_en,
  output logic                          diagnostic_pin
);
  import frg_pkg::*;

  // Pins and fault comparators are asynchronous: three-stage sync
  logic [2:0]                 hi_s_q;
  logic [2:0]                 lo_s_q;
  logic [9:0]                 flt_s1_q;
  logic [9:0]                 flt_s2_q;
  logic [9:0]                 flt_s3_q;
  logic                       hi_q;
  logic                       lo_q;
  frg_faults_t                flt_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hi_s_q   <= 3'h0;
      lo_s_q   <= 3'h0;
      flt_s1_q <= 10'h000;
      flt_s2_q <= 10'h000;
      flt_s3_q <= 10'h000;
    end
    else if (clk_en)
    begin
      hi_s_q   <= {hi_s_q[1:0], phase_w_high_input};
      lo_s_q   <= {lo_s_q[1:0], phase_w_low_input};
      flt_s1_q <= fault_in;
      flt_s2_q <= flt_s1_q;
      flt_s3_q <= flt_s2_q;
    end
  end

  // A change counts only once stages two and three agree
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hi_q  <= 1'b0;
      lo_q  <= 1'b0;
      flt_q <= '0;
    end
    else if (clk_en)
    begin
      if (hi_s_q[1] == hi_s_q[2])
        hi_q <= hi_s_q[2];
      if (lo_s_q[1] == lo_s_q[2])
        lo_q <= lo_s_q[2];
      for (int i = 0; i < 10; i++)
        if (flt_s2_q[i] == flt_s3_q[i])
          flt_q[i] <= flt_s3_q[i];
    end
  end

  // Control registers
  logic                       w_dis_q;
  logic                       opt_q;
  logic                       gate_w_q;
  frg_act_t                   act_q [`FRG_NUM_MON];
  logic [`FRG_NUM_MON-1:0]    mon_flag_q;
  logic                       inh_flag_q;
  logic [`FRG_NUM_MON-1:0]    hold_q;
  logic [`FRG_NUM_MON-1:0]    mon_raw;
  logic                       clr_wr;

  assign clr_wr = reg_wr && (reg_addr == `FRG_ADDR_STAT);
  assign mon_raw = {flt_q.battery_uv, flt_q.amp_supply_ov,
                    flt_q.amp_supply_uv, flt_q.logic_supply_ov,
                    flt_q.pump_ov};

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      w_dis_q  <= 1'b0;
      opt_q    <= 1'b0;
      gate_w_q <= 1'b0;
      for (int i = 0; i < `FRG_NUM_MON; i++)
        act_q[i] <= `FRG_ACT_ALL_OFF;
    end
    else if (clk_en && reg_wr)
    begin
      if (reg_addr == `FRG_ADDR_CTRL)
      begin
        w_dis_q  <= reg_wdata[`FRG_BIT_W_DIS];
        opt_q    <= reg_wdata[`FRG_BIT_OPT];
        gate_w_q <= reg_wdata[`FRG_BIT_GATE_W];
      end
      else if (reg_addr == `FRG_ADDR_ACT0)
      begin
        for (int i = 0; i < 4; i++)
          act_q[i] <= reg_wdata[i*4 +: `FRG_ACT_W];
      end
      else if (reg_addr == `FRG_ADDR_ACT1)
        act_q[`FRG_MON_BATT_UV] <= reg_wdata[`FRG_ACT_W-1:0];
    end
  end

  // Effective action per monitor; battery has its own table
  frg_act_t                   eff [`FRG_NUM_MON];
  logic [`FRG_NUM_MON-1:0]    mon_en;
  always_comb
  begin
    for (int i = 0; i < `FRG_NUM_MON; i++)
    begin
      eff[i]    = act_q[i];
      mon_en[i] = (act_q[i] != `FRG_ACT_DISABLE);
    end
    // Battery monitor never disabled; map onto all-off or motor-off
    mon_en[`FRG_MON_BATT_UV] = 1'b1;
    if (act_q[`FRG_MON_BATT_UV] <= `FRG_ACT_ALL_OFF)
      eff[`FRG_MON_BATT_UV] = `FRG_ACT_ALL_OFF;
    else
      eff[`FRG_MON_BATT_UV] = `FRG_ACT_MOTOR;
  end

  // Sticky monitor flags; set wins over clear
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      mon_flag_q <= '0;
    else if (clk_en)
    begin
      for (int i = 0; i < `FRG_NUM_MON; i++)
        if (mon_raw[i] && mon_en[i])
          mon_flag_q[i] <= 1'b1;
        else if (clr_wr && reg_wdata[i])
          mon_flag_q[i] <= 1'b0;
    end
  end

  // Hold latches persist after the cause until the flag is cleared
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      hold_q <= '0;
    else if (clk_en)
    begin
      for (int i = 0; i < `FRG_NUM_MON; i++)
        if (mon_raw[i] && eff[i] == `FRG_ACT_HOLD && i != `FRG_MON_BATT_UV)
          hold_q[i] <= 1'b1;
        else if (clr_wr && reg_wdata[i])
          hold_q[i] <= 1'b0;
    end
  end

  // Combine live faults into off requests
  logic                       all_off;
  logic                       motor_off;
  logic                       cp_off;
  logic                       lsup_uv;
  always_comb
  begin
    lsup_uv   = flt_q.logic_supply_uv;
    all_off   = lsup_uv || hold_q != '0;
    motor_off = 1'b0;
    cp_off    = lsup_uv || hold_q != '0;
    for (int i = 0; i < `FRG_NUM_MON; i++)
      if (mon_raw[i] && mon_en[i])
      begin
        case (eff[i])
          `FRG_ACT_ALL_OFF: all_off = 1'b1;
          `FRG_ACT_MOTOR:   motor_off = 1'b1;
          `FRG_ACT_ALL_CP:
          begin
            all_off = 1'b1;
            cp_off  = 1'b1;
          end
          default: ;  // Report only keeps running
        endcase
      end
  end

  // Inhibit status flag for the W phase
  logic                       both_hi;
  assign both_hi = hi_q && lo_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      inh_flag_q <= 1'b0;
    else if (clk_en)
    begin
      // Evaluated even with the gate disabled
      if (both_hi && !w_dis_q && opt_q)
        inh_flag_q <= 1'b1;
      else if (clr_wr && reg_wdata[`FRG_CLR_INH_W])
        inh_flag_q <= 1'b0;
    end
  end

  // Gate outputs
  logic                       drive_ok;
  logic                       hi_d;
  logic                       lo_d;
  assign drive_ok = gate_w_q && !all_off && !motor_off;
  always_comb
  begin
    hi_d = 1'b0;
    lo_d = 1'b0;
    if (drive_ok)
    begin
      if (!both_hi)
      begin
        hi_d = hi_q;
        lo_d = lo_q;
      end
      else if (w_dis_q)
      begin
        hi_d = 1'b1;
        lo_d = 1'b1;
      end
      // Otherwise inhibited: both low
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      phase_w_high_output <= 1'b0;
      phase_w_low_output  <= 1'b0;
      aux_drivers_on      <= 1'b0;
      pump_on             <= 1'b0;
      osc_on              <= 1'b0;
      vds_monitor_en      <= 1'b0;
      diagnostic_pin      <= 1'b0;
    end
    else if (clk_en)
    begin
      phase_w_high_output <= hi_d;
      phase_w_low_output  <= lo_d;
      aux_drivers_on      <= !all_off;
      pump_on             <= !cp_off;
      osc_on              <= !lsup_uv;
      // Suspended while forced off, back on when running
      vds_monitor_en      <= !all_off && !motor_off;
      diagnostic_pin      <= !(lsup_uv || inh_flag_q
                               || mon_flag_q != '0);
    end
  end

  // Register read, data in the cycle after the strobe
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 32'h0;
    else if (clk_en)
    begin
      reg_rdata <= 32'h0;
      if (reg_rd)
      begin
        if (reg_addr == `FRG_ADDR_CTRL)
          reg_rdata[2:0] <= {gate_w_q, opt_q, w_dis_q};
        else if (reg_addr == `FRG_ADDR_ACT0)
          reg_rdata[15:0] <= {1'b0, act_q[3], 1'b0, act_q[2],
                              1'b0, act_q[1], 1'b0, act_q[0]};
        else if (reg_addr == `FRG_ADDR_ACT1)
          reg_rdata[2:0] <= act_q[`FRG_MON_BATT_UV];
        else if (reg_addr == `FRG_ADDR_STAT)
          reg_rdata[7:0] <= {!(all_off || motor_off), cp_off,
                             inh_flag_q, mon_flag_q};
      end
    end
  end
endmodule : frg_gate_ctrl

/* File: hw/frg_defs.svh */
// Constants for the fault response and gate control block
`ifndef FRG_DEFS_SVH
`define FRG_DEFS_SVH
`define FRG_ACT_W        3
`define FRG_ACT_DISABLE  3'h0
`define FRG_ACT_REPORT   3'h1
`define FRG_ACT_ALL_OFF  3'h2
`define FRG_ACT_MOTOR    3'h3
`define FRG_ACT_ALL_CP   3'h4
`define FRG_ACT_HOLD     3'h5
`define FRG_NUM_MON      5
`define FRG_MON_PUMP_OV  0
`define FRG_MON_LSUP_OV  1
`define FRG_MON_AMP_UV   2
`define FRG_MON_AMP_OV   3
`define FRG_MON_BATT_UV  4
`define FRG_ADDR_W       4
`define FRG_ADDR_CTRL    4'h0
`define FRG_ADDR_ACT0    4'h4
`define FRG_ADDR_ACT1    4'h8
`define FRG_ADDR_STAT    4'hc
`define FRG_ADDR_CLR     4'h0
`define FRG_BIT_W_DIS    0
`define FRG_BIT_OPT      1
`define FRG_BIT_GATE_W   2
`define FRG_STAT_INH_W   5
`define FRG_STAT_CP      6
`define FRG_STAT_VDS     7
`define FRG_CLR_INH_W    5
`endif

/* File: hw/frg_pkg.sv */
// Types shared by the fault response and gate control block
`include "frg_defs.svh"
package frg_pkg;
  typedef logic [`FRG_ACT_W-1:0] frg_act_t;
  typedef struct packed {
    logic high;
    logic low;
  } frg_pair_t;
  typedef struct packed {
    logic pump_ov;
    logic logic_supply_ov;
    logic amp_supply_uv;
    logic amp_supply_ov;
    logic battery_uv;
    logic logic_supply_uv;
    logic gate_source_ov;
    logic over_temp;
    logic drain_source;
    logic osc_fault;
  } frg_faults_t;
endpackage : frg_pkg

/* File: sim/frg_gate_ctrl_monitor.sv */
// Port-level checks for the W-phase gate and fault response block
`timescale 1ns/1ps
`include "frg_defs.svh"
module frg_gate_ctrl_monitor
(
  input wire logic                 clk,
  input wire logic                 reset_n,
  input wire logic                 clk_en,
  input wire logic [3:0]           reg_addr,
  input wire logic [31:0]          reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [31:0]          reg_rdata,
  input wire logic                 phase_w_high_input,
  input wire logic                 phase_w_low_input,
  input wire frg_pkg::frg_faults_t fault_in,
  input wire logic                 phase_w_high_output,
  input wire logic                 phase_w_low_output,
  input wire logic                 aux_drivers_on,
  input wire logic                 pump_on,
  input wire logic                 osc_on,
  input wire logic                 vds_monitor_en,
  input wire logic                 diagnostic_pin
);
  import frg_pkg::*;
  logic [2:0] ctrl_q;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Shadow of the control register, the body is not visible from here
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ctrl_q <= 3'h0;
    else if (clk_en && reg_wr && reg_addr == `FRG_ADDR_CTRL)
      ctrl_q <= reg_wdata[2:0];
  end
  a_pair_guard: assert property (
    phase_w_high_output && phase_w_low_output
    |-> ctrl_q[0] || $past(ctrl_q[0]) || $past(ctrl_q[0], 2))
    else $error("both outputs high while inhibit active");
  a_gate_hold: assert property (
    phase_w_high_output || phase_w_low_output
    |-> ctrl_q[2] || $past(ctrl_q[2]) || $past(ctrl_q[2], 2))
    else $error("output high with gate disabled");
  a_inhibit_off: assert property (
    (phase_w_high_input && phase_w_low_input && !ctrl_q[0])[*8]
    |-> !phase_w_high_output && !phase_w_low_output)
    else $error("inhibited pair not driven low");
  a_follow: assert property (
    ($stable({phase_w_high_input, phase_w_low_input}) && ctrl_q[2]
     && !(phase_w_high_input && phase_w_low_input) && vds_monitor_en)[*8]
    |-> phase_w_high_output == phase_w_high_input
        && phase_w_low_output == phase_w_low_input)
    else $error("outputs do not follow inputs");
  a_diagnostic_pin_flag: assert property (
    $past(reg_rd && reg_addr == `FRG_ADDR_STAT) && |reg_rdata[5:0]
    |-> !diagnostic_pin)
    else $error("flag set but diagnostic pin high");
  a_vds_off: assert property (
    !aux_drivers_on |-> !vds_monitor_en)
    else $error("drain-source monitor on while drivers off");
  a_pump_all_off: assert property (
    !pump_on |-> !aux_drivers_on && !phase_w_high_output
                 && !phase_w_low_output)
    else $error("pump off but drivers still on");
  a_uv_stop: assert property (
    fault_in.logic_supply_uv[*6] |-> !osc_on && !pump_on && !diagnostic_pin)
    else $error("logic undervoltage did not stop the device");
endmodule : frg_gate_ctrl_monitor

bind frg_gate_ctrl frg_gate_ctrl_monitor i_mon
(
  .clk, .reset_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .phase_w_high_input, .phase_w_low_input, .fault_in,
  .phase_w_high_output, .phase_w_low_output, .aux_drivers_on, .pump_on,
  .osc_on, .vds_monitor_en, .diagnostic_pin
);

/* File: sim/frg_pwm_model.sv */
// Host timer model driving the W-phase PWM pins
`timescale 1ns/1ps
module frg_pwm_model
(
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire frg_pkg::frg_pair_t req,
  output logic                    high_pin,
  output logic                    low_pin
);
  import frg_pkg::*;
  // Pins move only after an edge, like a timer compare output
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      high_pin <= 1'b0;
      low_pin  <= 1'b0;
    end
    else
    begin
      high_pin <= req.high;
      low_pin  <= req.low;
    end
  end
endmodule : frg_pwm_model

/* File: sim/tb_frg_gate_ctrl.sv */
// Self-checking bench for the W-phase gate and fault response block
`timescale 1ns/1ps
`include "frg_defs.svh"
module tb_frg_gate_ctrl;
  import frg_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        clk_en = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  frg_pair_t   pwm = '0;
  frg_faults_t fault_in = '0;
  logic        phase_w_high_input, phase_w_low_input;
  logic        phase_w_high_output, phase_w_low_output, aux_drivers_on;
  logic        pump_on, osc_on, vds_monitor_en, diagnostic_pin;
  logic [4:0]  st;
  logic [1:0]  pin_t [4] = '{2'b11, 2'b11, 2'b10, 2'b01};
  logic [1:0]  exp_t [4] = '{2'b00, 2'b11, 2'b10, 2'b01};
  int          err_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  // Pins rest at low-only after the pin table, so the low side is watched
  assign st = {phase_w_low_output, aux_drivers_on, pump_on,
               vds_monitor_en, diagnostic_pin};
  always #2 clk = ~clk;
  frg_pwm_model i_pwm (.clk, .reset_n, .req(pwm),
    .high_pin(phase_w_high_input), .low_pin(phase_w_low_input));
  frg_gate_ctrl i_dut (.clk, .reset_n, .clk_en, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .phase_w_high_input,
    .phase_w_low_input, .fault_in, .phase_w_high_output,
    .phase_w_low_output, .aux_drivers_on, .pump_on, .osc_on,
    .vds_monitor_en, .diagnostic_pin);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata & m, e);
    @(posedge clk);
  endtask : rd
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      conclude();
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(`FRG_ADDR_CTRL, 32'hffffffff, 32'h0);
    rd(`FRG_ADDR_ACT0, 32'h7777, 32'h2222);
    rd(`FRG_ADDR_ACT1, 32'h7, 32'h2);
    rd(4'h2, 32'hffffffff, 32'h0);
    $display("test register reset done");
    // Gate off with status option: outputs low, flag still raised
    wr(`FRG_ADDR_CTRL, 32'h2);
    pwm <= 2'b11;
    repeat (8) @(posedge clk);
    chk({phase_w_high_output, phase_w_low_output}, 2'b00);
    rd(`FRG_ADDR_STAT, 32'h20, 32'h20);
    chk(diagnostic_pin, 1'b0);
    pwm <= 2'b00;
    repeat (8) @(posedge clk);
    rd(`FRG_ADDR_STAT, 32'h20, 32'h20);
    wr(`FRG_ADDR_STAT, 32'h20);
    rd(`FRG_ADDR_STAT, 32'h20, 32'h0);
    chk(diagnostic_pin, 1'b1);
    $display("test inhibit flag done");
    for (int i = 0; i < 4; i++)
    begin
      wr(`FRG_ADDR_CTRL, 32'h4 + {31'h0, i == 1});
      pwm <= pin_t[i];
      repeat (8) @(posedge clk);
      chk({phase_w_high_output, phase_w_low_output}, exp_t[i]);
      rd(`FRG_ADDR_STAT, 32'h20, 32'h0);
    end
    $display("test pin table done");
    // A write while frozen must not land
    clk_en <= 1'b0;
    wr(`FRG_ADDR_CTRL, 32'h0);
    clk_en <= 1'b1;
    repeat (2) @(posedge clk);
    chk({phase_w_high_output, phase_w_low_output}, 2'b01);
    rd(`FRG_ADDR_CTRL, 32'h7, 32'h4);
    $display("test clock enable done");
    for (int c = 0; c < 6; c++)
    begin
      wr(`FRG_ADDR_ACT0, 32'(c));
      fault_in.pump_ov <= 1'b1;
      repeat (8) @(posedge clk);
      chk(st, {c < 2, c < 2 || c == 3, c < 4, c < 2, c == 0});
      rd(`FRG_ADDR_STAT, 32'h1f, {31'h0, c != 0});
      fault_in.pump_ov <= 1'b0;
      repeat (8) @(posedge clk);
      chk(st, {{4{c != 5}}, c == 0});
      wr(`FRG_ADDR_STAT, 32'h1);
      repeat (8) @(posedge clk);
      chk(st, 5'h1f);
    end
    $display("test action codes done");
    for (int c = 0; c < 6; c++)
    begin
      wr(`FRG_ADDR_ACT1, 32'(c));
      fault_in.battery_uv <= 1'b1;
      repeat (8) @(posedge clk);
      chk({phase_w_low_output, aux_drivers_on}, {1'b0, c > 2});
      rd(`FRG_ADDR_STAT, 32'h1f, 32'h10);
      fault_in.battery_uv <= 1'b0;
      repeat (8) @(posedge clk);
      wr(`FRG_ADDR_STAT, 32'h10);
    end
    fault_in.logic_supply_uv <= 1'b1;
    repeat (8) @(posedge clk);
    chk({st, osc_on}, 6'h00);
    fault_in.logic_supply_uv <= 1'b0;
    repeat (8) @(posedge clk);
    chk({st, osc_on}, 6'h3f);
    $display("test supply faults done");
    conclude();
  end
endmodule : tb_frg_gate_ctrl
